// >>> rtl/atfl_pkg.sv
package atfl_pkg;

    // ==========================================
    // Register offsets
    localparam logic [8:0] OFS_CTRL_STATUS = 9'h044;
    localparam logic [8:0] OFS_CTRL_ACK    = 9'h004;
    localparam logic [8:0] OFS_CTRL_FIRST  = 9'h080;
    localparam logic [8:0] OFS_CTRL_CONT   = 9'h084;
    localparam logic [8:0] OFS_CTRL_FUPD   = 9'h088;
    localparam logic [8:0] OFS_CTRL_LAST   = 9'h08c;
    localparam logic [8:0] OFS_APP_CTRL    = 9'h0ec;
    localparam logic [8:0] OFS_BULK_SIZE   = 9'h104;
    localparam logic [8:0] OFS_BULK_FREE   = 9'h108;
    localparam logic [8:0] OFS_BULK_CONT   = 9'h10c;
    localparam logic [8:0] OFS_BULK_LAST   = 9'h110;
    localparam logic [8:0] OFS_HDR0        = 9'h1b0;
    localparam logic [8:0] OFS_HDR1        = 9'h1b4;
    localparam logic [8:0] OFS_HDR2        = 9'h1b8;
    localparam logic [8:0] OFS_HDR3        = 9'h1bc;

    // ==========================================
    // Field positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_SOURCE = 1;
    localparam int BIT_HEADER = 2;
    localparam int BIT_FLUSH  = 3;
    localparam int BIT_ACKERR = 23;
    localparam int ACK_LSB    = 24;
    localparam int TCODE_LSB  = 4;

    // ==========================================
    // Reset values
    localparam logic [7:0] RST_CTRL_QUADS = 8'h20;
    localparam logic [7:0] RST_BULK_UNITS = 8'h10;
    localparam logic [3:0] FMT_LAST       = 4'h0;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } atfl_hbus_t;

    typedef struct packed {
        logic        valid;
        logic        last;
        logic [31:0] data;
    } atfl_word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HDR  = 2'b01,
        ST_BODY = 2'b10
    } atfl_state_t;

endpackage : atfl_pkg

// >>> rtl/atfl_mem.sv
module atfl_mem #(
    parameter int AW = 6
) (
    input  wire logic          clk_sys,
    input  wire logic          we,
    input  wire logic [AW-1:0] wAddr,
    input  wire logic [32:0]   wData,
    input  wire logic [AW-1:0] rAddr,
    output logic      [32:0]   rData
);
    logic [32:0] mem [2**AW];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[wAddr] <= wData;
        end
        // Write-first bypass keeps a fresh head valid
        rData <= (we && (wAddr == rAddr)) ? wData : mem[rAddr];
    end
endmodule : atfl_mem

// >>> rtl/atfl_queue.sv
module atfl_queue #(
    parameter int AW = 6
) (
    input  wire logic          clk_sys,
    input  wire logic          srst,
    input  wire logic          flush,
    input  wire logic [AW:0]   limit,
    input  wire logic          push,
    input  wire logic [32:0]   pushData,
    input  wire logic          pop,
    output logic      [32:0]   headData,
    output logic               notEmpty,
    output logic      [AW:0]   count
);
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic          doPush;
    logic          doPop;

    assign doPush = push && (count < limit);
    assign doPop  = pop && (count != '0);
    assign notEmpty = (count != '0);

    always_ff @(posedge clk_sys) begin
        if (srst || flush) begin
            wp <= '0;
            rp <= '0;
            count <= '0;
        end else begin
            wp <= wp + AW'(doPush);
            rp <= rp + AW'(doPop);
            count <= count + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end

    atfl_mem #(.AW(AW)) uMem (
        .clk_sys(clk_sys),
        .we     (doPush),
        .wAddr  (wp),
        .wData  (pushData),
        .rAddr  (doPop ? rp + AW'(1) : rp),
        .rData  (headData)
    );
endmodule : atfl_queue

// >>> rtl/atfl_loader.sv
module atfl_loader #(
    parameter int CTRL_AW = 6,
    parameter int BULK_AW = 9
) (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire atfl_pkg::atfl_hbus_t hostBus,
    output logic      [31:0]         hostRdata,
    input  wire logic                bulkValid,
    input  wire logic [31:0]         bulkData,
    input  wire logic [2:0]          bulkFormat,
    output logic                     bulkReady,
    input  wire logic                ackValid,
    input  wire logic                ackError,
    input  wire logic [3:0]          ackCode,
    output atfl_pkg::atfl_word_t     txWord,
    input  wire logic                txReady,
    output logic                     txFromBulk
);
    if (CTRL_AW < 2 || CTRL_AW > 6 || BULK_AW < 4 || BULK_AW > 11) begin : g_bad_depth
        $error("atfl_loader: unsupported queue depth");
    end

    // ==========================================
    // State
    typedef struct packed {
        logic [31:0]          rdata;
        logic [7:0]           ctrlQuads;
        logic [7:0]           bulkUnits;
        logic [3:0]           appCtrl;
        logic [3:0][31:0]     hdr;
        logic [31:0]          ack;
        logic [7:0]           ctrlPkts;
        logic [7:0]           bulkPkts;
        logic                 immediate;
        atfl_pkg::atfl_state_t st;
        logic                 fromBulk;
        logic [1:0]           hdrIdx;
        atfl_pkg::atfl_word_t tx;
        logic                 bulkRdy;
        logic                 ackBulk;
    } atfl_regs_t;

    atfl_regs_t q;
    atfl_regs_t d;

    logic              wr;
    logic              rd;
    logic [8:0]        ad;
    logic [31:0]       wd;
    logic              cPush;
    logic [32:0]       cPushData;
    logic              cPop;
    logic [32:0]       cHead;
    logic              cNotEmpty;
    logic [CTRL_AW:0]  cCount;
    logic              bPush;
    logic [32:0]       bPushData;
    logic              bPop;
    logic [32:0]       bHead;
    logic              bNotEmpty;
    logic [BULK_AW:0]  bCount;
    logic [BULK_AW:0]  bLimit;
    logic [CTRL_AW:0]  cLimit;
    logic              enabled;
    logic              autoHdr;
    logic              bulkWrOk;
    logic [31:0]       padded;
    logic              bulkLast;
    logic              txFree;
    logic              ctrlLastSeen;

    assign wr = hostBus.wr;
    assign rd = hostBus.rd;
    assign ad = hostBus.addr;
    assign wd = hostBus.wdata;

    assign enabled = q.appCtrl[atfl_pkg::BIT_ENABLE];
    assign autoHdr = q.appCtrl[atfl_pkg::BIT_HEADER]
                     && (q.hdr[0][atfl_pkg::TCODE_LSB +: 4] <= 4'h1);

    // ==========================================
    // Queue limits
    always_comb begin
        cLimit = (q.ctrlQuads > 8'(2**CTRL_AW)) ? (CTRL_AW+1)'(2**CTRL_AW)
                                                : (CTRL_AW+1)'(q.ctrlQuads);
        if (12'({q.bulkUnits, 2'b00}) > 12'(2**BULK_AW)) begin
            bLimit = (BULK_AW+1)'(2**BULK_AW);
        end else begin
            bLimit = (BULK_AW+1)'({q.bulkUnits, 2'b00});
        end
    end

    // ==========================================
    // Control queue loading
    assign ctrlLastSeen = wr && (ad == atfl_pkg::OFS_CTRL_LAST);
    assign cPush = wr && ((ad == atfl_pkg::OFS_CTRL_FIRST)
                       || (ad == atfl_pkg::OFS_CTRL_CONT)
                       || (ad == atfl_pkg::OFS_CTRL_FUPD)
                       || ctrlLastSeen);
    assign cPushData = {ctrlLastSeen, wd};

    // ==========================================
    // Bulk queue loading
    always_comb begin
        padded = bulkData;
        unique case (bulkFormat)
            3'h1: padded = {bulkData[31:24], 24'h000000};
            3'h2: padded = {bulkData[31:16], 16'h0000};
            3'h3: padded = {bulkData[31:8], 8'h00};
            default: padded = bulkData;
        endcase
    end
    assign bulkLast = (bulkFormat != 3'h0);
    assign bulkWrOk = enabled && !q.appCtrl[atfl_pkg::BIT_SOURCE];
    always_comb begin
        bPush = 1'b0;
        bPushData = '0;
        if (enabled && q.appCtrl[atfl_pkg::BIT_SOURCE]) begin
            bPush = bulkValid && q.bulkRdy;
            bPushData = {bulkLast, padded};
        end else if (bulkWrOk && wr && (ad == atfl_pkg::OFS_BULK_CONT)) begin
            bPush = 1'b1;
            bPushData = {1'b0, wd};
        end else if (bulkWrOk && wr && (ad == atfl_pkg::OFS_BULK_LAST)) begin
            bPush = 1'b1;
            bPushData = {1'b1, wd};
        end
    end

    // ==========================================
    // Transmit sequencer
    assign txFree = !q.tx.valid || txReady;
    always_comb begin
        d = q;
        cPop = 1'b0;
        bPop = 1'b0;
        if (txReady) begin
            d.tx.valid = 1'b0;
        end
        d.bulkRdy = (bCount + (BULK_AW+1)'(2)) < bLimit;
        d.ctrlPkts = q.ctrlPkts + 8'(ctrlLastSeen);
        d.bulkPkts = q.bulkPkts + 8'(bPush && bPushData[32]);
        if (wr && (ad == atfl_pkg::OFS_CTRL_FIRST)) begin
            d.immediate = 1'b0;
        end
        if (wr && (ad == atfl_pkg::OFS_CTRL_FUPD)) begin
            d.immediate = 1'b1;
        end
        unique case (q.st)
            atfl_pkg::ST_IDLE: begin
                if (txFree && cNotEmpty && (q.immediate || q.ctrlPkts != 8'h00)) begin
                    d.st = atfl_pkg::ST_BODY;
                    d.fromBulk = 1'b0;
                end else if (txFree && q.bulkPkts != 8'h00) begin
                    d.fromBulk = 1'b1;
                    d.hdrIdx = 2'd0;
                    d.st = autoHdr ? atfl_pkg::ST_HDR : atfl_pkg::ST_BODY;
                end
            end
            atfl_pkg::ST_HDR: begin
                if (txFree) begin
                    d.tx = '{valid: 1'b1, last: 1'b0, data: q.hdr[q.hdrIdx]};
                    d.hdrIdx = q.hdrIdx + 2'd1;
                    if (q.hdrIdx == 2'd3) begin
                        d.st = atfl_pkg::ST_BODY;
                    end
                end
            end
            atfl_pkg::ST_BODY: begin
                if (txFree && !q.fromBulk && cNotEmpty) begin
                    cPop = 1'b1;
                    d.tx = '{valid: 1'b1, last: cHead[32], data: cHead[31:0]};
                    if (cHead[32]) begin
                        d.ctrlPkts = d.ctrlPkts - 8'h01;
                        d.st = atfl_pkg::ST_IDLE;
                    end
                end else if (txFree && q.fromBulk && bNotEmpty) begin
                    bPop = 1'b1;
                    d.tx = '{valid: 1'b1, last: bHead[32], data: bHead[31:0]};
                    if (bHead[32]) begin
                        d.bulkPkts = d.bulkPkts - 8'h01;
                        d.st = atfl_pkg::ST_IDLE;
                    end
                end
            end
            default: d.st = atfl_pkg::ST_IDLE;
        endcase
        if (q.appCtrl[atfl_pkg::BIT_FLUSH]) begin
            d.appCtrl[atfl_pkg::BIT_FLUSH] = 1'b0;
            d.bulkPkts = 8'h00;
            if (q.fromBulk) begin
                d.st = atfl_pkg::ST_IDLE;
            end
        end
        if (q.tx.valid && txReady && q.tx.last) begin
            d.ackBulk = q.fromBulk;
        end
        if (ackValid && !q.ackBulk) begin
            d.ack = '0;
            d.ack[atfl_pkg::BIT_ACKERR] = ackError;
            d.ack[atfl_pkg::ACK_LSB +: 4] = ackCode;
        end

        // Register writes and reads
        if (wr) begin
            unique case (ad)
                atfl_pkg::OFS_CTRL_STATUS: d.ctrlQuads = wd[7:0];
                atfl_pkg::OFS_APP_CTRL:    d.appCtrl = wd[3:0];
                atfl_pkg::OFS_BULK_SIZE:   d.bulkUnits = wd[7:0];
                atfl_pkg::OFS_HDR0:        d.hdr[0] = wd;
                atfl_pkg::OFS_HDR1:        d.hdr[1] = wd;
                atfl_pkg::OFS_HDR2:        d.hdr[2] = wd;
                atfl_pkg::OFS_HDR3:        d.hdr[3] = wd;
                default: ;
            endcase
        end
        d.rdata = q.rdata;
        if (rd) begin
            unique case (ad)
                atfl_pkg::OFS_CTRL_ACK:    d.rdata = q.ack;
                atfl_pkg::OFS_CTRL_STATUS: d.rdata = {8'h00, 8'(cCount), 8'h00,
                                                      q.ctrlQuads};
                atfl_pkg::OFS_APP_CTRL:    d.rdata = {28'h0, q.appCtrl};
                atfl_pkg::OFS_BULK_SIZE:   d.rdata = {24'h0, q.bulkUnits};
                atfl_pkg::OFS_BULK_FREE:   d.rdata = 32'(bLimit - bCount);
                atfl_pkg::OFS_HDR0:        d.rdata = q.hdr[0];
                atfl_pkg::OFS_HDR1:        d.rdata = q.hdr[1];
                atfl_pkg::OFS_HDR2:        d.rdata = q.hdr[2];
                atfl_pkg::OFS_HDR3:        d.rdata = q.hdr[3];
                default:                   d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= '0;
            q.ctrlQuads <= atfl_pkg::RST_CTRL_QUADS;
            q.bulkUnits <= atfl_pkg::RST_BULK_UNITS;
            q.st <= atfl_pkg::ST_IDLE;
        end else begin
            q <= d;
        end
    end

    // ==========================================
    // Queues
    atfl_queue #(.AW(CTRL_AW)) uCtrlQ (
        .clk_sys (clk_sys),
        .srst    (srst),
        .flush   (1'b0),
        .limit   (cLimit),
        .push    (cPush),
        .pushData(cPushData),
        .pop     (cPop),
        .headData(cHead),
        .notEmpty(cNotEmpty),
        .count   (cCount)
    );

    atfl_queue #(.AW(BULK_AW)) uBulkQ (
        .clk_sys (clk_sys),
        .srst    (srst),
        .flush   (q.appCtrl[atfl_pkg::BIT_FLUSH]),
        .limit   (bLimit),
        .push    (bPush),
        .pushData(bPushData),
        .pop     (bPop),
        .headData(bHead),
        .notEmpty(bNotEmpty),
        .count   (bCount)
    );

    assign hostRdata  = q.rdata;
    assign txWord     = q.tx;
    assign txFromBulk = q.fromBulk;
    assign bulkReady  = q.bulkRdy;
endmodule : atfl_loader

// >>> verif/atfl_loader_properties.sv
module atfl_loader_properties (
    input wire logic                 clk_sys,
    input wire logic                 srst,
    input wire atfl_pkg::atfl_hbus_t hostBus,
    input wire logic [31:0]          hostRdata,
    input wire logic                 bulkValid,
    input wire logic [2:0]           bulkFormat,
    input wire logic                 bulkReady,
    input wire logic                 ackValid,
    input wire logic                 ackError,
    input wire logic [3:0]           ackCode,
    input wire atfl_pkg::atfl_word_t txWord,
    input wire logic                 txReady,
    input wire logic                 txFromBulk
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Helpers
    logic [8:0] a;
    logic       w;
    logic       r;
    logic [4:0] ackSeen_q;
    logic       ackCtrl_q;
    assign a = hostBus.addr;
    assign w = hostBus.wr;
    assign r = hostBus.rd;
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ackSeen_q <= 5'h00;
            ackCtrl_q <= 1'b1;
        end else begin
            if (txWord.valid && txReady && txWord.last) begin
                ackCtrl_q <= !txFromBulk;
            end
            if (ackValid && ackCtrl_q) begin
                ackSeen_q <= {ackCode, ackError};
            end
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // ==========================================
    // Properties
    chk_tx_hold: assert property (txWord.valid && !txReady |=>
        txWord.valid && $stable(txWord.data) && $stable(txWord.last))
        else $error("tx word changed before accept");
    chk_src_hold: assert property (txWord.valid && !txReady |=> $stable(txFromBulk))
        else $error("tx source changed before accept");
    chk_rd_hold: assert property (!r |=> $stable(hostRdata))
        else $error("read data changed without read");
    chk_reset_quiet: assert property ($fell(srst) |->
        !txWord.valid && !bulkReady && !txFromBulk && hostRdata == 32'h0)
        else $error("outputs not idle after reset");
    chk_ack_read: assert property (r && a == atfl_pkg::OFS_CTRL_ACK |=>
        hostRdata[27:23] == $past(ackSeen_q))
        else $error("ack status not as received");
    chk_size_back: assert property (w && a == atfl_pkg::OFS_BULK_SIZE ##2
        r && a == atfl_pkg::OFS_BULK_SIZE |=> hostRdata[7:0] == $past(hostBus.wdata[7:0], 3))
        else $error("bulk size readback wrong");
    chk_hdr_back: assert property (w && a == atfl_pkg::OFS_HDR0 ##2
        r && a == atfl_pkg::OFS_HDR0 |=> hostRdata == $past(hostBus.wdata, 3))
        else $error("header word readback wrong");
    chk_last_send: assert property (w && a == atfl_pkg::OFS_CTRL_LAST |->
        ##[1:64] txWord.valid && txWord.last && !txFromBulk)
        else $error("control packet not sent");
    cover property (txWord.valid && txReady && txWord.last && txFromBulk);
    cover property (bulkValid && bulkReady && bulkFormat != 3'h0);
    cover property (ackValid && ackError);
endmodule : atfl_loader_properties

bind atfl_loader atfl_loader_properties u_props (.clk_sys(clk_sys), .srst(srst),
    .hostBus(hostBus), .hostRdata(hostRdata), .bulkValid(bulkValid), .bulkFormat(bulkFormat),
    .bulkReady(bulkReady), .ackValid(ackValid), .ackError(ackError), .ackCode(ackCode),
    .txWord(txWord), .txReady(txReady), .txFromBulk(txFromBulk));

// >>> verif/atfl_link_model.sv
module atfl_link_model (
    input  wire logic                 clk_sys,
    input  wire logic                 srst,
    input  wire atfl_pkg::atfl_word_t txWord,
    input  wire logic                 txFromBulk,
    input  wire logic                 slow,
    input  wire logic                 errIn,
    input  wire logic [3:0]           codeIn,
    output logic                      txReady,
    output logic                      ackValid,
    output logic                      ackError,
    output logic [3:0]                ackCode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [33:0] got[$];
    logic        fire;
    assign fire = txWord.valid && txReady && txWord.last;
    // ==========================================
    // Accept words, one ack per packet, no resend
    always @(posedge clk_sys) begin
        if (srst) begin
            txReady  <= 1'b0;
            ackValid <= 1'b0;
        end else begin
            txReady  <= slow ? !txReady : 1'b1;
            ackValid <= fire;
            ackError <= fire ? errIn : !errIn;
            ackCode  <= fire ? codeIn : ~codeIn;
            if (txWord.valid && txReady) begin
                got.push_back({txFromBulk, txWord.last, txWord.data});
            end
        end
    end
endmodule : atfl_link_model

// >>> verif/tb_atfl_loader.sv
module tb_atfl_loader;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_sys;
    logic                 srst;
    atfl_pkg::atfl_hbus_t hostBus;
    logic [31:0]          hostRdata;
    logic                 bulkValid;
    logic [31:0]          bulkData;
    logic [2:0]           bulkFormat;
    logic                 bulkReady;
    logic                 ackValid;
    logic                 ackError;
    logic [3:0]           ackCode;
    atfl_pkg::atfl_word_t txWord;
    logic                 txReady;
    logic                 txFromBulk;
    logic                 slow;
    logic                 errIn;
    logic [3:0]           codeIn;
    int                   n_errors;
    int                   comparisons;
    logic [33:0]          ex[$];
    logic [31:0]          bw[$];
    logic [31:0]          hw[4] = '{32'h0000_0010, 32'h1b1b_0001, 32'h2b2b_0002, 32'h3b3b_0003};

    atfl_loader u_dut (.clk_sys(clk_sys), .srst(srst), .hostBus(hostBus), .hostRdata(hostRdata),
        .bulkValid(bulkValid), .bulkData(bulkData), .bulkFormat(bulkFormat),
        .bulkReady(bulkReady), .ackValid(ackValid), .ackError(ackError), .ackCode(ackCode),
        .txWord(txWord), .txReady(txReady), .txFromBulk(txFromBulk));
    atfl_link_model u_link (.clk_sys(clk_sys), .srst(srst), .txWord(txWord),
        .txFromBulk(txFromBulk), .slow(slow), .errIn(errIn), .codeIn(codeIn),
        .txReady(txReady), .ackValid(ackValid), .ackError(ackError), .ackCode(ackCode));

    // ==========================================
    // Tasks
    task automatic results;
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [8:0] ad, input logic [31:0] d);
        @(posedge clk_sys);
        #1;
        hostBus = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge clk_sys);
        #1;
        hostBus.wr = 1'b0;
    endtask : wr
    task automatic rdc(input string what, input logic [8:0] ad, input logic [31:0] e,
                       input logic [31:0] m);
        @(posedge clk_sys);
        #1;
        hostBus = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0};
        @(posedge clk_sys);
        #1;
        hostBus.rd = 1'b0;
        chk(what, {2'b00, e & m}, {2'b00, hostRdata & m});
    endtask : rdc
    task automatic pkt(input string what);
        int n;
        n = 0;
        while (u_link.got.size() < ex.size() && n < 400) begin
            @(posedge clk_sys);
            n++;
        end
        chk(what, 34'(ex.size()), 34'(u_link.got.size()));
        foreach (ex[i]) begin
            if (i < u_link.got.size()) chk(what, ex[i], u_link.got[i]);
        end
        u_link.got.delete();
    endtask : pkt
    task automatic burst(input logic [2:0] lastFmt);
        int n;
        @(posedge clk_sys);
        #1;
        bulkValid = 1'b1;
        foreach (bw[i]) begin
            bulkData = bw[i];
            bulkFormat = (i == bw.size() - 1) ? lastFmt : 3'h0;
            n = 0;
            while (bulkReady !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
            @(posedge clk_sys);
            #1;
        end
        bulkValid = 1'b0;
        bulkData = ~bulkData;
    endtask : burst

    // ==========================================
    // Clock, watchdog, tests
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        results();
    end
    initial begin
        hostBus = '0;
        {bulkValid, bulkData, bulkFormat} = '0;
        {srst, slow, errIn, codeIn} = {3'b111, 4'h5};
        repeat (6) @(posedge clk_sys);
        #1;
        srst = 1'b0;
        rdc("ctrl size", atfl_pkg::OFS_CTRL_STATUS, {24'h0, atfl_pkg::RST_CTRL_QUADS}, 32'hff00ff);
        rdc("bulk size", atfl_pkg::OFS_BULK_SIZE, {24'h0, atfl_pkg::RST_BULK_UNITS}, 32'hff);
        rdc("bulk free", atfl_pkg::OFS_BULK_FREE, {22'h0, atfl_pkg::RST_BULK_UNITS, 2'b00}, '1);
        wr(atfl_pkg::OFS_CTRL_FIRST, 32'h0000_0a10);
        wr(atfl_pkg::OFS_CTRL_CONT, 32'h1111_1111);
        wr(atfl_pkg::OFS_CTRL_CONT, 32'h2222_2222);
        repeat (20) @(posedge clk_sys);
        chk("early tx", 34'h0, 34'(u_link.got.size()));
        rdc("ctrl used", atfl_pkg::OFS_CTRL_STATUS, 32'h0003_0000, 32'hff_0000);
        wr(atfl_pkg::OFS_CTRL_LAST, 32'h3333_3333);
        ex = {34'h0_0000_0a10, 34'h0_1111_1111, 34'h0_2222_2222, 34'h1_3333_3333};
        pkt("ctrl packet");
        rdc("ack error", atfl_pkg::OFS_CTRL_ACK, 32'h0580_0000, 32'h0f80_0000);
        errIn = 1'b0;
        wr(atfl_pkg::OFS_CTRL_FUPD, 32'h4444_4444);
        ex = {34'h0_4444_4444};
        pkt("update word");
        wr(atfl_pkg::OFS_CTRL_LAST, 32'h5555_5555);
        ex = {34'h1_5555_5555};
        pkt("update last");
        rdc("ack normal", atfl_pkg::OFS_CTRL_ACK, 32'h0500_0000, 32'h0f80_0000);
        for (int i = 3; i >= 0; i--) wr(atfl_pkg::OFS_HDR0 + 9'(4 * i), hw[i]);
        rdc("hdr0", atfl_pkg::OFS_HDR0, hw[0], '1);
        wr(atfl_pkg::OFS_APP_CTRL, 32'h5);
        rdc("app ctrl", atfl_pkg::OFS_APP_CTRL, 32'h5, 32'h7);
        wr(atfl_pkg::OFS_BULK_CONT, 32'hd000_0001);
        wr(atfl_pkg::OFS_BULK_LAST, 32'hd000_0002);
        ex.delete();
        foreach (hw[i]) ex.push_back({2'b10, hw[i]});
        ex = {ex, 34'h2_d000_0001, 34'h3_d000_0002};
        pkt("host auto hdr");
        wr(atfl_pkg::OFS_HDR0, 32'h0000_0040);
        wr(atfl_pkg::OFS_BULK_CONT, 32'he000_0001);
        wr(atfl_pkg::OFS_BULK_LAST, 32'he000_0002);
        ex = {34'h2_e000_0001, 34'h3_e000_0002};
        pkt("other tcode");
        wr(atfl_pkg::OFS_APP_CTRL, 32'h1);
        wr(atfl_pkg::OFS_BULK_CONT, 32'hf000_0001);
        wr(atfl_pkg::OFS_BULK_CONT, 32'hf000_0002);
        rdc("free used", atfl_pkg::OFS_BULK_FREE, {22'h0, atfl_pkg::RST_BULK_UNITS, 2'b00} - 2, '1);
        wr(atfl_pkg::OFS_APP_CTRL, 32'h9);
        rdc("free flush", atfl_pkg::OFS_BULK_FREE, {22'h0, atfl_pkg::RST_BULK_UNITS, 2'b00}, '1);
        wr(atfl_pkg::OFS_BULK_LAST, 32'hf000_0003);
        ex = {34'h3_f000_0003};
        pkt("after flush");
        wr(atfl_pkg::OFS_APP_CTRL, 32'h0);
        wr(atfl_pkg::OFS_BULK_LAST, 32'hf000_0004);
        repeat (20) @(posedge clk_sys);
        chk("disabled", 34'h0, 34'(u_link.got.size()));
        wr(atfl_pkg::OFS_BULK_SIZE, 32'h2);
        rdc("size", atfl_pkg::OFS_BULK_SIZE, 32'h2, 32'hff);
        rdc("free small", atfl_pkg::OFS_BULK_FREE, 32'h8, '1);
        wr(atfl_pkg::OFS_HDR0, hw[0]);
        hw[3] = 32'h000a_0000;
        wr(atfl_pkg::OFS_HDR3, hw[3]);
        wr(atfl_pkg::OFS_APP_CTRL, 32'h7);
        bw = {32'hc000_0001, 32'hc000_0002, 32'haabb_ccdd};
        chk("bulk ready", 34'h1, 34'(bulkReady));
        burst(3'h2);
        ex.delete();
        foreach (hw[i]) ex.push_back({2'b10, hw[i]});
        ex = {ex, 34'h2_c000_0001, 34'h2_c000_0002, 34'h3_aabb_0000};
        pkt("bulk port");
        results();
    end
endmodule : tb_atfl_loader
